// ---- rtl/osc_tuning_regs.sv ----
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
// How it works
// - output frequency is the frequency word over 2^32 times the sample rate.
// - an all-zero frequency word, the reset value, leaves the oscillator at DC.
// - the frequency word only acts while both the first down-converter enable and the oscillator enable are set.
// - the phase offset word is two byte registers, low then high, both resetting to zero.
// - the phase offset word is the offset in degrees times 2^16 over 360.
// - the phase offset acts only in down-conversion mode and only on the variant that has it.
module osc_tuning_regs
#(
	parameter bit HAS_DOWNCONV = 1'b1
)
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic [31:0] s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [31:0] s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic [15:0]      osc_phase_o,
	output logic             osc_running_o,
	output logic             dither_lfsr_en_o
);
	osc_cfg_if cfg_bus ();

	logic [7:0]  freq_byte_r [4];
	logic [7:0]  phase_low_r;
	logic [7:0]  phase_high_r;
	logic [7:0]  phase_low_c1_r;
	logic        dc1_en_r;
	logic        lfsr_en_r;
	logic        osc_en_r;
	logic        aw_held_r;
	logic        w_held_r;
	logic [31:0] waddr_r;
	logic [31:0] wdata_r;
	logic [3:0]  wstrb_r;
	logic        bvalid_r;
	logic [1:0]  bresp_r;
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	logic        wr_go;
	logic        wr_hit;
	logic [7:0]  wr_idx;
	logic [7:0]  rd_idx;
	logic        rd_hit;
	logic [31:0] rd_word;
	logic [15:0] phase_now;

	// index of a register from a byte address
	function automatic logic [7:0] reg_index(input logic [31:0] addr);
		return addr[osc_regs_pkg::IDX_MSB:osc_regs_pkg::IDX_LSB];
	endfunction

	// true when the address names an implemented register
	function automatic logic reg_mapped(input logic [31:0] addr);
		logic [7:0] idx;
		idx = addr[osc_regs_pkg::IDX_MSB:osc_regs_pkg::IDX_LSB];
		if (addr[31:osc_regs_pkg::ADDR_TOP] != 22'h000000)
			return 1'b0;
		return (idx == osc_regs_pkg::IDX_CTRL) || (idx == osc_regs_pkg::IDX_STATUS) ||
			((idx >= osc_regs_pkg::IDX_FREQ_BYTE0) && (idx <= osc_regs_pkg::IDX_PHASE_LOW_C1));
	endfunction

	// write channel handshakes, each channel held until the pair is complete
	assign s_axi_awready_o = !aw_held_r && !bvalid_r;
	assign s_axi_wready_o  = !w_held_r && !bvalid_r;
	assign wr_go           = aw_held_r && w_held_r && !bvalid_r;
	assign wr_idx          = reg_index(waddr_r);
	assign wr_hit          = reg_mapped(waddr_r);

	// address capture
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			aw_held_r <= 1'b0;
			waddr_r   <= osc_regs_pkg::RST_WORD;
		end
		else if (s_axi_awvalid_i && s_axi_awready_o)
		begin
			aw_held_r <= 1'b1;
			waddr_r   <= s_axi_awaddr_i;
		end
		else if (wr_go)
			aw_held_r <= 1'b0;
	end

	// data capture
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			w_held_r <= 1'b0;
			wdata_r  <= osc_regs_pkg::RST_WORD;
			wstrb_r  <= 4'h0;
		end
		else if (s_axi_wvalid_i && s_axi_wready_o)
		begin
			w_held_r <= 1'b1;
			wdata_r  <= s_axi_wdata_i;
			wstrb_r  <= s_axi_wstrb_i;
		end
		else if (wr_go)
			w_held_r <= 1'b0;
	end

	// write response, unmapped addresses answer slave error
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			bvalid_r <= 1'b0;
			bresp_r  <= osc_regs_pkg::RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_r <= 1'b1;
			bresp_r  <= wr_hit ? osc_regs_pkg::RESP_OKAY : osc_regs_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready_i)
			bvalid_r <= 1'b0;
	end

	// frequency word bytes, byte lane 0 carries the register
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			for (int i = 0; i < 4; i++)
				freq_byte_r[i] <= osc_regs_pkg::RST_BYTE;
		end
		else if (wr_go && wstrb_r[0])
		begin
			for (int i = 0; i < 4; i++)
				if (wr_idx == osc_regs_pkg::IDX_FREQ_BYTE0 + 8'(i))
					freq_byte_r[i] <= wdata_r[7:0];
		end
	end

	// phase offset bytes and the first low-byte replica
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			phase_low_r    <= osc_regs_pkg::RST_BYTE;
			phase_high_r   <= osc_regs_pkg::RST_BYTE;
			phase_low_c1_r <= osc_regs_pkg::RST_BYTE;
		end
		else if (wr_go && wstrb_r[0])
		begin
			if (wr_idx == osc_regs_pkg::IDX_PHASE_LOW)
				phase_low_r <= wdata_r[7:0];
			if (wr_idx == osc_regs_pkg::IDX_PHASE_HIGH)
				phase_high_r <= wdata_r[7:0];
			if (wr_idx == osc_regs_pkg::IDX_PHASE_LOW_C1)
				phase_low_c1_r <= wdata_r[7:0];
		end
	end

	// control bits, the host is expected to set all three together
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			dc1_en_r  <= 1'b0;
			lfsr_en_r <= 1'b0;
			osc_en_r  <= 1'b0;
		end
		else if (wr_go && wstrb_r[0] && wr_idx == osc_regs_pkg::IDX_CTRL)
		begin
			dc1_en_r  <= wdata_r[osc_regs_pkg::CTRL_DC1_EN_BIT];
			lfsr_en_r <= wdata_r[osc_regs_pkg::CTRL_LFSR_EN_BIT];
			osc_en_r  <= wdata_r[osc_regs_pkg::CTRL_OSC_EN_BIT];
		end
	end

	// oscillator configuration
	assign cfg_bus.freq_word  = {freq_byte_r[3], freq_byte_r[2],
		freq_byte_r[1], freq_byte_r[0]};
	assign cfg_bus.phase_word = {phase_high_r, phase_low_r};
	assign cfg_bus.run        = dc1_en_r && osc_en_r;
	assign cfg_bus.offset_en  = HAS_DOWNCONV;

	osc_accum u_accum
	(
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.cfg        (cfg_bus.core)
	);

	osc_phase_sum u_phase_sum
	(
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.cfg        (cfg_bus.sum),
		.phase_o    (phase_now)
	);

	assign osc_phase_o      = phase_now;
	assign osc_running_o    = cfg_bus.run;
	assign dither_lfsr_en_o = lfsr_en_r;

	// read decode, byte registers sit in the low byte, the status phase in the low 16 bits
	assign rd_idx = reg_index(s_axi_araddr_i);
	assign rd_hit = reg_mapped(s_axi_araddr_i);

	always_comb
	begin
		rd_word = osc_regs_pkg::RST_WORD;
		unique case (rd_idx)
			osc_regs_pkg::IDX_CTRL:
			begin
				rd_word[osc_regs_pkg::CTRL_DC1_EN_BIT]  = dc1_en_r;
				rd_word[osc_regs_pkg::CTRL_LFSR_EN_BIT] = lfsr_en_r;
				rd_word[osc_regs_pkg::CTRL_OSC_EN_BIT]  = osc_en_r;
			end
			osc_regs_pkg::IDX_FREQ_BYTE0:   rd_word[7:0]  = freq_byte_r[0];
			osc_regs_pkg::IDX_FREQ_BYTE1:   rd_word[7:0]  = freq_byte_r[1];
			osc_regs_pkg::IDX_FREQ_BYTE2:   rd_word[7:0]  = freq_byte_r[2];
			osc_regs_pkg::IDX_FREQ_BYTE3:   rd_word[7:0]  = freq_byte_r[3];
			osc_regs_pkg::IDX_PHASE_LOW:    rd_word[7:0]  = phase_low_r;
			osc_regs_pkg::IDX_PHASE_HIGH:   rd_word[7:0]  = phase_high_r;
			osc_regs_pkg::IDX_PHASE_LOW_C1: rd_word[7:0]  = phase_low_c1_r;
			osc_regs_pkg::IDX_STATUS:       rd_word[15:0] = phase_now;
			default:                        rd_word       = osc_regs_pkg::RST_WORD;
		endcase
	end

	// read channel, one read in flight
	assign s_axi_arready_o = !rvalid_r;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
		begin
			rvalid_r <= 1'b0;
			rdata_r  <= osc_regs_pkg::RST_WORD;
			rresp_r  <= osc_regs_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid_i && s_axi_arready_o)
		begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_hit ? rd_word : osc_regs_pkg::RST_WORD;
			rresp_r  <= rd_hit ? osc_regs_pkg::RESP_OKAY : osc_regs_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready_i)
			rvalid_r <= 1'b0;
	end

	assign s_axi_bvalid_o = bvalid_r;
	assign s_axi_bresp_o  = bresp_r;
	assign s_axi_rvalid_o = rvalid_r;
	assign s_axi_rdata_o  = rdata_r;
	assign s_axi_rresp_o  = rresp_r;

	a_byte_order: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_go && wstrb_r[0] && wr_idx == osc_regs_pkg::IDX_FREQ_BYTE1
		|=> cfg_bus.freq_word[15:8] == $past(wdata_r[7:0]))
		else $error("byte one did not land in bits 15:8");

	a_top_byte: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_go && wstrb_r[0] && wr_idx == osc_regs_pkg::IDX_FREQ_BYTE3
		|=> cfg_bus.freq_word[31:24] == $past(wdata_r[7:0]))
		else $error("byte three did not land in bits 31:24");

	a_phase_bytes: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		wr_go && wstrb_r[0] && wr_idx == osc_regs_pkg::IDX_PHASE_HIGH
		|=> cfg_bus.phase_word[15:8] == $past(wdata_r[7:0]))
		else $error("high phase byte not stored");

	a_reset_zero: assert property (@(posedge core_clk_i)
		$fell(sys_rst_i) |-> cfg_bus.freq_word == 32'h00000000 && cfg_bus.phase_word == 16'h0000)
		else $error("words not zero after reset");

	a_run_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		!dc1_en_r [*3] |-> osc_phase_o == 16'h0000)
		else $error("output moved while the converter is disabled");

	a_bvalid_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
		else $error("write response dropped before taken");

	a_rvalid_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
		else $error("read data dropped before taken");

	a_unmapped_err: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		s_axi_arvalid_i && s_axi_arready_o && !rd_hit
		|=> s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h00000000)
		else $error("unmapped read not answered with slave error");
endmodule

// ---- rtl/osc_regs_pkg.sv ----
package osc_regs_pkg;
	// word widths
	localparam int unsigned ACC_WIDTH   = 32;
	localparam int unsigned PHASE_WIDTH = 16;
	localparam int unsigned BYTE_WIDTH  = 8;

	// register indices, byte address is four times the index
	localparam logic [7:0] IDX_CTRL         = 8'h80;
	localparam logic [7:0] IDX_FREQ_BYTE0   = 8'h82;
	localparam logic [7:0] IDX_FREQ_BYTE1   = 8'h83;
	localparam logic [7:0] IDX_FREQ_BYTE2   = 8'h84;
	localparam logic [7:0] IDX_FREQ_BYTE3   = 8'h85;
	localparam logic [7:0] IDX_PHASE_LOW    = 8'h86;
	localparam logic [7:0] IDX_PHASE_HIGH   = 8'h87;
	localparam logic [7:0] IDX_PHASE_LOW_C1 = 8'h88;
	localparam logic [7:0] IDX_STATUS       = 8'hA0;

	// index field inside the byte address
	localparam int unsigned IDX_LSB  = 2;
	localparam int unsigned IDX_MSB  = 9;
	localparam int unsigned ADDR_TOP = 10;

	// control register bit positions
	localparam int unsigned CTRL_DC1_EN_BIT  = 0;
	localparam int unsigned CTRL_LFSR_EN_BIT = 2;
	localparam int unsigned CTRL_OSC_EN_BIT  = 5;

	// reset values
	localparam logic [7:0]  RST_BYTE  = 8'h00;
	localparam logic [31:0] RST_WORD  = 32'h00000000;
	localparam logic [15:0] RST_PHASE = 16'h0000;

	// axi response codes
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ---- rtl/osc_cfg_if.sv ----
`timescale 1ns/10ps
interface osc_cfg_if;
	logic [31:0] freq_word;
	logic [15:0] phase_word;
	logic        run;
	logic        offset_en;
	logic [31:0] acc;

	modport cfg
	(
		output freq_word,
		output phase_word,
		output run,
		output offset_en,
		input  acc
	);
	modport core
	(
		input  freq_word,
		input  run,
		output acc
	);
	modport sum
	(
		input  acc,
		input  phase_word,
		input  run,
		input  offset_en
	);
endinterface

// ---- rtl/osc_accum.sv ----
`timescale 1ns/10ps
module osc_accum
(
	input  wire logic core_clk_i,
	input  wire logic sys_rst_i,
	osc_cfg_if.core   cfg
);
	logic [31:0] acc_r;
	logic [31:0] acc_nxt;

	// wrap-around sum is the fraction of 2^32 per sample
	always_comb
	begin
		if (cfg.run)
			acc_nxt = acc_r + cfg.freq_word;
		else
			acc_nxt = osc_regs_pkg::RST_WORD;
	end

	// one step per core sample
	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			acc_r <= osc_regs_pkg::RST_WORD;
		else
			acc_r <= acc_nxt;
	end

	assign cfg.acc = acc_r;

	a_acc_step: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		cfg.run |=> acc_r == $past(acc_r) + $past(cfg.freq_word))
		else $error("accumulator did not advance by the frequency word");

	a_dc_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		(cfg.freq_word == 32'h00000000 && cfg.run) [*2] |-> $stable(acc_r))
		else $error("zero frequency word moved the accumulator");
endmodule

// ---- rtl/osc_phase_sum.sv ----
`timescale 1ns/10ps
module osc_phase_sum
(
	input  wire logic        core_clk_i,
	input  wire logic        sys_rst_i,
	osc_cfg_if.sum           cfg,
	output logic      [15:0] phase_o
);
	logic [15:0] offset;
	logic [15:0] phase_r;

	// offset counts in units of 360/2^16 degrees
	assign offset = (cfg.run && cfg.offset_en) ? cfg.phase_word
		: osc_regs_pkg::RST_PHASE;

	always_ff @(posedge core_clk_i)
	begin
		if (sys_rst_i)
			phase_r <= osc_regs_pkg::RST_PHASE;
		else
			phase_r <= cfg.acc[31:16] + offset;
	end

	assign phase_o = phase_r;

	a_phase_out: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
		cfg.run && cfg.offset_en |=> phase_r == 16'($past(cfg.acc[31:16]) + $past(cfg.phase_word)))
		else $error("output phase is not accumulator plus offset");
endmodule

// ---- sim/test_osc_tuning_regs.sv ----
`timescale 1ns/10ps
module test_osc_tuning_regs;
	logic        core_clk = 1'b0;
	logic        sys_rst  = 1'b1;
	logic [31:0] awaddr   = 32'h0;
	logic [31:0] wdata    = 32'h0;
	logic [31:0] araddr   = 32'h0;
	logic [3:0]  wstrb    = 4'hF;
	logic        awvalid  = 1'b0;
	logic        wvalid   = 1'b0;
	logic        bready   = 1'b0;
	logic        arvalid  = 1'b0;
	logic        rready   = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, running, dither;
	logic [1:0]  bresp, rresp, resp;
	logic [31:0] rdata, rd, fw;
	logic [15:0] phase, p0, w;
	int          bad_count = 0;
	int          checks    = 0;

	// 40 MHz core clock
	always #12.5 core_clk = ~core_clk;

	osc_tuning_regs #(.HAS_DOWNCONV(1'b1)) osc_tuning_regs_inst
	(
		.core_clk_i(core_clk), .sys_rst_i(sys_rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .osc_phase_o(phase),
		.osc_running_o(running), .dither_lfsr_en_o(dither)
	);

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// write cycle: both channels offered together, response code returned
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [3:0] st,
		output logic [1:0] r);
		bit aw_done;
		bit w_done;
		bit b_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		b_done = 1'b0;
		r = 2'h3;
		awaddr <= {22'h0, idx, 2'h0};
		wdata <= d;
		wstrb <= st;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// only the watchdog ends a wait that never completes
		while (!b_done)
		begin
			@(negedge core_clk);
			aw_done |= awvalid && awready;
			w_done |= wvalid && wready;
			b_done = (bvalid === 1'b1);
			if (b_done)
				r = bresp;
			@(posedge core_clk);
			if (aw_done)
				awvalid <= 1'b0;
			if (w_done)
				wvalid <= 1'b0;
		end
		bready <= 1'b0;
		// let an edge pass so the next call never re-raises bready in this step
		@(posedge core_clk);
	endtask

	// read cycle: address held until taken, data taken with rvalid
	task automatic rdr(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
		bit a;
		bit done;
		a = 1'b0;
		done = 1'b0;
		r = 2'h3;
		d = 32'h0;
		araddr <= {22'h0, idx, 2'h0};
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!done)
		begin
			@(negedge core_clk);
			a |= arvalid && arready;
			done = (rvalid === 1'b1);
			if (done)
			begin
				r = rresp;
				d = rdata;
			end
			@(posedge core_clk);
			if (a)
				arvalid <= 1'b0;
		end
		rready <= 1'b0;
		@(posedge core_clk);
	endtask

	task automatic put(input logic [7:0] idx, input logic [31:0] d);
		wr(idx, d, 4'hF, resp);
		check("bresp", {30'h0, resp}, {30'h0, osc_regs_pkg::RESP_OKAY});
	endtask

	task automatic expect_reg(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
		rdr(idx, rd, resp);
		check("rresp", {30'h0, resp}, {30'h0, er});
		check("rdata", rd, exp);
	endtask

	function automatic logic [15:0] deg_word(input int deg);
		return 16'((deg * 65536) / 360);
	endfunction

	// main sequence
	initial
	begin
		logic [7:0]  b [7];
		logic [15:0] k;
		int          degs [3];
		void'($urandom(25919));
		repeat (20) @(posedge core_clk);
		sys_rst <= 1'b0;
		for (int i = 0; i < 7; i++)
			expect_reg(8'(osc_regs_pkg::IDX_FREQ_BYTE0 + i), 32'h0, 2'h0);
		@(negedge core_clk);
		check("osc_phase_o", {16'h0, phase}, 32'h0);
		$display("test reset values done");
		@(posedge core_clk);
		for (int i = 0; i < 7; i++)
		begin
			b[i] = (i == 6) ? b[4] : 8'($urandom);
			put(8'(osc_regs_pkg::IDX_FREQ_BYTE0 + i), {24'h0, b[i]});
		end
		for (int i = 0; i < 7; i++)
			expect_reg(8'(osc_regs_pkg::IDX_FREQ_BYTE0 + i), {24'h0, b[i]}, 2'h0);
		wr(osc_regs_pkg::IDX_PHASE_HIGH, {24'h0, ~b[5]}, 4'h0, resp);
		check("bresp", {30'h0, resp}, {30'h0, osc_regs_pkg::RESP_OKAY});
		expect_reg(osc_regs_pkg::IDX_PHASE_HIGH, {24'h0, b[5]}, 2'h0);
		wr(8'h81, 32'hFF, 4'hF, resp);
		check("bresp", {30'h0, resp}, {30'h0, osc_regs_pkg::RESP_SLVERR});
		expect_reg(8'h81, 32'h0, osc_regs_pkg::RESP_SLVERR);
		$display("test register access done");
		k = 16'($urandom) | 16'h1;
		fw = {k, 16'h0};
		for (int i = 0; i < 4; i++)
			put(8'(osc_regs_pkg::IDX_FREQ_BYTE0 + i), {24'h0, fw[8*i +: 8]});
		put(osc_regs_pkg::IDX_CTRL, 32'h20);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		check("osc_running_o", {31'h0, running}, 32'h0);
		check("osc_phase_o", {16'h0, phase}, 32'h0);
		@(posedge core_clk);
		put(osc_regs_pkg::IDX_CTRL, 32'h25);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		p0 = phase;
		@(negedge core_clk);
		check("phase step", {16'h0, 16'(phase - p0)}, {16'h0, k});
		check("osc_running_o", {31'h0, running}, 32'h1);
		check("dither_lfsr_en_o", {31'h0, dither}, 32'h1);
		@(posedge core_clk);
		expect_reg(osc_regs_pkg::IDX_CTRL, 32'h25, 2'h0);
		$display("test frequency done");
		degs = '{90, 180, int'($urandom % 360)};
		foreach (degs[j])
		begin
			w = deg_word(degs[j]);
			put(osc_regs_pkg::IDX_CTRL, 32'h0);
			for (int i = 0; i < 4; i++)
				put(8'(osc_regs_pkg::IDX_FREQ_BYTE0 + i), 32'h0);
			put(osc_regs_pkg::IDX_PHASE_LOW, {24'h0, w[7:0]});
			put(osc_regs_pkg::IDX_PHASE_HIGH, {24'h0, w[15:8]});
			put(osc_regs_pkg::IDX_PHASE_LOW_C1, {24'h0, w[7:0]});
			// the odd replica is not held here, so the block refuses it
			wr(8'h89, {24'h0, w[15:8]}, 4'hF, resp);
			check("bresp", {30'h0, resp}, {30'h0, osc_regs_pkg::RESP_SLVERR});
			put(osc_regs_pkg::IDX_CTRL, 32'h25);
			repeat (4) @(posedge core_clk);
			@(negedge core_clk);
			check("osc_phase_o", {16'h0, phase}, {16'h0, w});
			@(posedge core_clk);
			expect_reg(osc_regs_pkg::IDX_STATUS, {16'h0, w}, 2'h0);
			put(osc_regs_pkg::IDX_CTRL, 32'h0);
			repeat (4) @(posedge core_clk);
			@(negedge core_clk);
			check("osc_phase_o", {16'h0, phase}, 32'h0);
			@(posedge core_clk);
		end
		$display("test phase offset done");
		stop_test();
	end

	// watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge core_clk);
		bad_count++;
		stop_test();
	end
endmodule
